// ### rtl/spcb_map.vh
// constants of the serial port control and buffer block
// assumes 32-bit apb; one register per aligned word
// How it works
// - reset zeroes the control register.
// - rx done sets by mode: bit 8, stop, ninth.
// - tx done sets after the last data bit.
// - rx bit nine holds ninth bit, or mode 1 stop.
// - modes 2/3 send tx bit nine.
// - rx enable gates reception, starts mode 0 rx.
// - mode 1 multiproc drops bad-stop frames.
// - modes 2/3 multiproc drop frames with ninth 0.
// - mode 0 clock divides by 12, or 4 if multiproc.
// - frame check on: top bit is sticky frame error.
// - frame check on: top bit writes keep the mode.
// - reset zeroes the rx buffer and empties the tx fifo.
// - one address: write tx buffer, read rx buffer.
// - frame check enable picks top bit role.
// - baud double: 16x or 32x, else 64x.
// - irq from done flags only while enabled.
`ifndef SPCB_MAP_VH
`define SPCB_MAP_VH
// register indices; byte address is four times the index
`define SPCB_IDX_CTRL    8'h06
`define SPCB_IDX_BUF     8'h07
`define SPCB_IDX_MODE    8'h08
`define SPCB_IDX_PHASE   8'h09
`define SPCB_ADDR_CTRL   (`SPCB_IDX_CTRL << 2)
`define SPCB_ADDR_BUF    (`SPCB_IDX_BUF << 2)
`define SPCB_ADDR_MODE   (`SPCB_IDX_MODE << 2)
`define SPCB_ADDR_PHASE  (`SPCB_IDX_PHASE << 2)
// control register fields
`define SPCB_CTL_RXDONE  0
`define SPCB_CTL_TXDONE  1
`define SPCB_CTL_RXB9    2
`define SPCB_CTL_TXB9    3
`define SPCB_CTL_RXEN    4
`define SPCB_CTL_MPSEL   5
`define SPCB_CTL_MODELO  6
`define SPCB_CTL_MODEHI  7
// mode extension register fields
`define SPCB_MX_FCHK     0
`define SPCB_MX_BDBL     1
`define SPCB_MX_IRQEN    2
`define SPCB_RST_CTRL    8'h00
`define SPCB_RST_BUF     8'h00
`define SPCB_RST_MODE    3'h0
`define SPCB_RST_PHASE   16'h0000
// modes
`define SPCB_MODE_SYNC   2'b00
`define SPCB_MODE_A8     2'b01
`define SPCB_MODE_A9F    2'b10
`define SPCB_MODE_A9V    2'b11
// rate divisors in system clocks or baud ticks
`define SPCB_M0_DIV_SLOW 24'h00000C
`define SPCB_M0_DIV_FAST 24'h000004
`define SPCB_M2_DIV_FAST 24'h000020
`define SPCB_M2_DIV_SLOW 24'h000040
`endif

// ### rtl/spcb_core.v
// serial port block: apb registers, tx fifo, shifters
// assumes one clock, sync active-low reset, async rxd pin
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`include "spcb_map.vh"

// transmit fifo; the writer stalls on in_ready low
module spcb_fifo #(
    parameter W  = 8,
    parameter D  = 16,
    parameter AW = 4
) (
    input  wire         clock,
    input  wire         rst_n,
    input  wire         ce,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem [0:D-1];
    reg [AW:0]  wr_q;
    reg [AW:0]  rd_q;
    wire        full  = (wr_q[AW] != rd_q[AW]) &&
                        (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire        empty = (wr_q == rd_q);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_q[AW-1:0]];
    // pointers carry a wrap bit so full and empty stay distinct
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end
        else if (ce)
        begin
            if (in_valid && !full)
            begin
                mem[wr_q[AW-1:0]] <= in_data;
                wr_q <= wr_q + 1'b1;
            end
            if (out_ready && !empty)
                rd_q <= rd_q + 1'b1;
        end
    end
endmodule

module spcb_core #(
    parameter DEPTH = 16
) (
    input  wire        clock,
    input  wire        rst_n,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         txd,
    input  wire        rxd_in,
    output reg         rxd_out,
    output reg         rxd_oe,
    output reg         irq
);
    localparam RX_IDLE  = 3'd0;
    localparam RX_START = 3'd1;
    localparam RX_DATA  = 3'd2;
    localparam RX_STOP  = 3'd3;
    localparam RX_SYNC  = 3'd4;

    // control, mode extension and phase registers
    reg        rx_done_flag_q, tx_done_flag_q, rx_bit_nine_q, tx_bit_nine_q;
    reg        rx_enable_q, multiproc_select_q, mode_select_low_q;
    reg        mode_select_high_q, frame_error_flag_q;
    reg        frame_check_enable_q, baud_double_select_q, port_irq_enable_q;
    reg [15:0] phase_q;
    reg [7:0]  rx_buf_q;
    // synchroniser and receiver
    reg        rx_meta_q, rx_sync_q, rx_prev_q;
    reg [2:0]  rx_st_q;
    reg [23:0] rx_cnt_q;
    reg [8:0]  rx_sh_q;
    reg [3:0]  rx_n_q;
    reg [1:0]  rx_mode_q;
    reg        rx_clk_q;
    // transmitter
    reg        tx_busy_q, tx_sync_q, tx_line_q;
    reg [9:0]  tx_sh_q;
    reg [3:0]  tx_left_q;
    reg [23:0] tx_cnt_q;

    wire [1:0] mode = {mode_select_high_q, mode_select_low_q};
    wire       acc  = psel && penable;
    wire       is_ctrl  = (paddr == `SPCB_ADDR_CTRL);
    wire       is_buf   = (paddr == `SPCB_ADDR_BUF);
    wire       is_mode  = (paddr == `SPCB_ADDR_MODE);
    wire       is_phase = (paddr == `SPCB_ADDR_PHASE);
    wire       hit      = is_ctrl || is_buf || is_mode || is_phase;
    wire       done     = acc && pready;
    wire       wr_ctrl  = done && pwrite && is_ctrl;
    wire       wr_mode  = done && pwrite && is_mode;
    wire       wr_phase = done && pwrite && is_phase;
    wire       wr_buf   = done && pwrite && is_buf;
    wire       fifo_in_ready;
    wire       fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire       stall    = is_buf && pwrite && !fifo_in_ready;

    // top bit shows the error flag or the high mode bit
    wire       top_bit = frame_check_enable_q ? frame_error_flag_q
                                              : mode_select_high_q;
    wire [7:0] ctrl_rd = {top_bit, mode_select_low_q, multiproc_select_q,
                          rx_enable_q, tx_bit_nine_q, rx_bit_nine_q,
                          tx_done_flag_q, rx_done_flag_q};
    reg [31:0] rd_mux;
    always @*
    begin
        rd_mux = 32'h0;
        if (is_ctrl)
            rd_mux = {24'h0, ctrl_rd};
        else if (is_buf)
            rd_mux = {24'h0, rx_buf_q};
        else if (is_mode)
            rd_mux = {29'h0, port_irq_enable_q,
                      baud_double_select_q, frame_check_enable_q};
        else if (is_phase)
            rd_mux = {16'h0000, phase_q};
    end

    // bit times: mode 2 in system clocks, modes 1 and 3 in baud ticks
    wire [23:0] ph1    = {8'h00, phase_q} + 24'h1;
    wire [23:0] m13per = baud_double_select_q
                       ? {ph1[19:0], 4'h0} : {ph1[17:0], 6'h00};
    wire [23:0] m2per  = baud_double_select_q
                       ? `SPCB_M2_DIV_FAST : `SPCB_M2_DIV_SLOW;
    wire [23:0] bitper = (mode == `SPCB_MODE_A9F) ? m2per : m13per;
    wire [23:0] m0per  = multiproc_select_q
                       ? `SPCB_M0_DIV_FAST : `SPCB_M0_DIV_SLOW;
    wire [23:0] m0half = {1'b0, m0per[23:1]};

    // mode 0 shares the data pin, so directions exclude
    wire tx_go = !tx_busy_q && fifo_out_valid && (rx_st_q != RX_SYNC);
    wire rx_m0_go = rx_enable_q && (mode == `SPCB_MODE_SYNC) &&
                    !rx_done_flag_q && !tx_busy_q && !fifo_out_valid &&
                    (rx_st_q == RX_IDLE);

    spcb_fifo #(
        .W  (8),
        .D  (DEPTH),
        .AW (4)
    ) u_txq (
        .clock     (clock),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_valid  (wr_buf),
        .in_ready  (fifo_in_ready),
        .in_data   (pwdata[7:0]),
        .out_valid (fifo_out_valid),
        .out_ready (tx_go),
        .out_data  (fifo_out_data)
    );

    // answer one cycle into access; a full fifo holds it off
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            if (acc && !pready && !stall)
            begin
                pready  <= 1'b1;
                prdata  <= pwrite ? 32'h0 : rd_mux;
                pslverr <= !hit;
            end
            else
            begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // hardware events from the shifters
    reg       ri_set, ti_set, fe_set, rb8_ld, rb8_val, buf_ld;
    reg [7:0] buf_val;
    wire      tick_tx = tx_busy_q && (tx_cnt_q == 24'h0);
    always @*
    begin
        ti_set = tick_tx &&
                 (tx_sync_q ? (tx_left_q == 4'h0)
                            : (tx_left_q == 4'h1));
    end

    // control bits: hardware set wins over software clear
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            {mode_select_high_q, mode_select_low_q, multiproc_select_q,
             rx_enable_q, tx_bit_nine_q, rx_bit_nine_q, tx_done_flag_q,
             rx_done_flag_q} <= `SPCB_RST_CTRL;
            frame_error_flag_q <= 1'b0;
            {port_irq_enable_q, baud_double_select_q,
             frame_check_enable_q} <= `SPCB_RST_MODE;
            phase_q  <= `SPCB_RST_PHASE;
            irq      <= 1'b0;
        end
        else if (ce)
        begin
            rx_done_flag_q <= ri_set | (wr_ctrl ? pwdata[`SPCB_CTL_RXDONE]
                                                : rx_done_flag_q);
            tx_done_flag_q <= ti_set | (wr_ctrl ? pwdata[`SPCB_CTL_TXDONE]
                                                : tx_done_flag_q);
            rx_bit_nine_q  <= rb8_ld ? rb8_val
                            : (wr_ctrl ? pwdata[`SPCB_CTL_RXB9]
                                       : rx_bit_nine_q);
            if (wr_ctrl)
            begin
                tx_bit_nine_q      <= pwdata[`SPCB_CTL_TXB9];
                rx_enable_q        <= pwdata[`SPCB_CTL_RXEN];
                multiproc_select_q <= pwdata[`SPCB_CTL_MPSEL];
                mode_select_low_q  <= pwdata[`SPCB_CTL_MODELO];
            end
            // mode bit frozen while top bit is the error flag
            if (wr_ctrl && !frame_check_enable_q)
                mode_select_high_q <= pwdata[`SPCB_CTL_MODEHI];
            frame_error_flag_q <= fe_set |
                ((wr_ctrl && frame_check_enable_q)
                 ? pwdata[`SPCB_CTL_MODEHI] : frame_error_flag_q);
            if (wr_mode)
            begin
                frame_check_enable_q <= pwdata[`SPCB_MX_FCHK];
                baud_double_select_q <= pwdata[`SPCB_MX_BDBL];
                port_irq_enable_q    <= pwdata[`SPCB_MX_IRQEN];
            end
            if (wr_phase)
                phase_q <= pwdata[15:0];
            irq <= port_irq_enable_q &&
                   (rx_done_flag_q || tx_done_flag_q);
        end
    end

    // transmitter: start, 8 data lsb first, ninth, stop; mode 1 ends on the ninth, mode 0 sends 8 data only
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            tx_busy_q <= 1'b0;
            tx_sync_q <= 1'b0;
            tx_line_q <= 1'b1;
            tx_sh_q   <= 10'h3FF;
            tx_left_q <= 4'h0;
            tx_cnt_q  <= 24'h0;
            rxd_out   <= 1'b1;
            rxd_oe    <= 1'b0;
        end
        else if (ce)
        begin
            if (tx_go)
            begin
                tx_busy_q <= 1'b1;
                if (mode == `SPCB_MODE_SYNC)
                begin
                    tx_sync_q <= 1'b1;
                    tx_sh_q   <= {3'h7, fifo_out_data[7:1]};
                    tx_left_q <= 4'h7;
                    tx_cnt_q  <= m0per - 24'h000001;
                    tx_line_q <= 1'b0;
                    rxd_out   <= fifo_out_data[0];
                    rxd_oe    <= 1'b1;
                end
                else
                begin
                    tx_sync_q <= 1'b0;
                    tx_sh_q   <= {1'b1, tx_bit_nine_q, fifo_out_data};
                    tx_left_q <= (mode == `SPCB_MODE_A8) ? 4'h9 : 4'hA;
                    tx_cnt_q  <= bitper - 24'h000001;
                    tx_line_q <= 1'b0;
                end
            end
            else if (tx_busy_q)
            begin
                if (tx_sync_q && tx_cnt_q == m0half)
                    tx_line_q <= 1'b1; // rising edge: far end samples
                if (tx_cnt_q != 24'h0)
                    tx_cnt_q <= tx_cnt_q - 24'h1;
                else if (tx_left_q == 4'h0)
                begin
                    tx_busy_q <= 1'b0;
                    tx_line_q <= 1'b1;
                    rxd_oe    <= 1'b0;
                    rxd_out   <= 1'b1;
                end
                else
                begin
                    tx_left_q <= tx_left_q - 4'h1;
                    tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
                    if (tx_sync_q)
                    begin
                        rxd_out   <= tx_sh_q[0];
                        tx_line_q <= 1'b0;
                        tx_cnt_q  <= m0per - 24'h000001;
                    end
                    else
                    begin
                        tx_line_q <= tx_sh_q[0];
                        tx_cnt_q  <= bitper - 24'h000001;
                    end
                end
            end
        end
    end

    // pin driver: tx owns the line, mode 0 receive borrows the clock
    always @(posedge clock)
    begin
        if (!rst_n)
            txd <= 1'b1;
        else if (ce)
            txd <= tx_busy_q ? tx_line_q
                 : ((rx_st_q == RX_SYNC) ? rx_clk_q : 1'b1);
    end

    // rxd passes two flops, then a third for the start edge; the second and third are looked at
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end
        else if (ce)
        begin
            rx_meta_q <= rxd_in;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end

    // receiver decisions, one sample at mid bit
    wire [8:0] nsh   = {rx_sync_q, rx_sh_q[8:1]};
    wire       tick_rx = (rx_cnt_q == 24'h0);
    always @*
    begin
        ri_set  = 1'b0;
        fe_set  = 1'b0;
        rb8_ld  = 1'b0;
        rb8_val = 1'b0;
        buf_ld  = 1'b0;
        buf_val = rx_sh_q[8:1];
        if (rx_st_q == RX_SYNC && tick_rx && rx_n_q == 4'h8)
        begin
            ri_set = 1'b1;
            buf_ld = 1'b1;
        end
        else if (rx_st_q == RX_DATA && tick_rx && rx_n_q == 4'h8 &&
                 !(multiproc_select_q && !rx_sync_q))
        begin
            ri_set  = 1'b1;
            buf_ld  = 1'b1;
            buf_val = nsh[7:0];
            rb8_ld  = 1'b1;
            rb8_val = rx_sync_q;
        end
        else if (rx_st_q == RX_STOP && tick_rx)
        begin
            fe_set = frame_check_enable_q && !rx_sync_q;
            if (rx_mode_q == `SPCB_MODE_A8 &&
                !(multiproc_select_q && !rx_sync_q))
            begin
                ri_set  = 1'b1;
                buf_ld  = 1'b1;
                rb8_ld  = 1'b1;
                rb8_val = rx_sync_q;
            end
        end
    end

    // receiver sequence; clearing the enable drops a frame in flight
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            rx_st_q   <= RX_IDLE;
            rx_cnt_q  <= 24'h0;
            rx_sh_q   <= 9'h000;
            rx_n_q    <= 4'h0;
            rx_mode_q <= `SPCB_MODE_SYNC;
            rx_clk_q  <= 1'b1;
            rx_buf_q  <= `SPCB_RST_BUF;
        end
        else if (ce)
        begin
            if (buf_ld)
                rx_buf_q <= buf_val;
            if (rx_cnt_q != 24'h0)
                rx_cnt_q <= rx_cnt_q - 24'h1;
            case (rx_st_q)
            RX_IDLE:
            begin
                rx_n_q <= 4'h0;
                if (rx_m0_go)
                begin
                    rx_st_q  <= RX_SYNC;
                    rx_cnt_q <= m0per - 24'h000001;
                    rx_clk_q <= 1'b0;
                end
                else if (rx_enable_q && mode != `SPCB_MODE_SYNC &&
                         rx_prev_q && !rx_sync_q)
                begin
                    rx_st_q   <= RX_START;
                    rx_mode_q <= mode;
                    rx_cnt_q  <= {1'b0, bitper[23:1]};
                end
            end
            RX_START:
            begin
                if (!rx_enable_q)
                    rx_st_q <= RX_IDLE;
                else if (tick_rx)
                begin
                    // a start bit gone high by mid bit was a glitch
                    rx_st_q  <= rx_sync_q ? RX_IDLE : RX_DATA;
                    rx_cnt_q <= bitper - 24'h000001;
                end
            end
            RX_DATA:
            begin
                if (!rx_enable_q)
                    rx_st_q <= RX_IDLE;
                else if (tick_rx)
                begin
                    rx_sh_q  <= nsh;
                    rx_n_q   <= rx_n_q + 4'h1;
                    rx_cnt_q <= bitper - 24'h000001;
                    if (rx_n_q == ((rx_mode_q == `SPCB_MODE_A8)
                                   ? 4'h7 : 4'h8))
                        rx_st_q <= RX_STOP;
                end
            end
            RX_STOP:
            begin
                if (!rx_enable_q || tick_rx)
                    rx_st_q <= RX_IDLE;
            end
            RX_SYNC:
            begin
                if (!rx_enable_q)
                begin
                    rx_st_q  <= RX_IDLE;
                    rx_clk_q <= 1'b1;
                end
                else if (rx_cnt_q == m0half)
                begin
                    rx_clk_q <= 1'b1;
                    rx_sh_q  <= nsh;
                    rx_n_q   <= rx_n_q + 4'h1;
                end
                else if (tick_rx)
                begin
                    if (rx_n_q == 4'h8)
                        rx_st_q <= RX_IDLE;
                    else
                    begin
                        rx_clk_q <= 1'b0;
                        rx_cnt_q <= m0per - 24'h000001;
                    end
                end
            end
            default:
                rx_st_q <= RX_IDLE;
            endcase
        end
    end
endmodule

// ### dv/spcb_props.sv
// checker of the serial port block's top ports
// assumes one clock and a bind from the bench
`timescale 1ns/1ns
`include "spcb_map.vh"
module spcb_props (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        txd,
    input wire logic        rxd_in,
    input wire logic        rxd_out,
    input wire logic        rxd_oe,
    input wire logic        irq
);
    logic en_q;
    logic wr_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // shadow of the irq enable and of any write since reset
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            en_q <= 1'b0;
            wr_q <= 1'b0;
        end
        else if (psel && penable && pready && pwrite)
        begin
            wr_q <= 1'b1;
            if (paddr == `SPCB_ADDR_MODE)
                en_q <= pwdata[`SPCB_MX_IRQEN];
        end
    end
    property p_rst;
        $rose(rst_n) |-> !pready && !pslverr && !irq && txd && !rxd_oe;
    endproperty
    property p_rdy_one;
        pready |=> !pready;
    endproperty
    property p_rdy_cause;
        pready |-> $past(psel && penable);
    endproperty
    property p_rd_fast;
        psel && penable && !pwrite && !pready |=> pready;
    endproperty
    property p_map;
        pready && paddr inside {`SPCB_ADDR_CTRL,
            `SPCB_ADDR_BUF, `SPCB_ADDR_MODE, `SPCB_ADDR_PHASE} |-> !pslverr;
    endproperty
    property p_err_zero;
        pready && pslverr |-> prdata == 32'h0;
    endproperty
    property p_irq_mask;
        !en_q && $past(!en_q) |-> !irq;
    endproperty
    property p_idle;
        !wr_q |-> txd;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle");
    a_rdy_one: assert property (p_rdy_one) else $error("long ready");
    a_rdy_cause: assert property (p_rdy_cause) else $error("stray ready");
    a_rd_fast: assert property (p_rd_fast) else $error("slow read");
    a_map: assert property (p_map) else $error("error on mapped");
    a_err_zero: assert property (p_err_zero) else $error("error data");
    a_irq_mask: assert property (p_irq_mask) else $error("masked irq");
    a_idle: assert property (p_idle) else $error("line not idle");
    c_err: cover property (pready && pslverr);
    c_frame: cover property ($fell(txd));
    c_irq: cover property (irq);
endmodule

// ### dv/spcb_peer.sv
// remote sender of 11-bit frames on the receive line
// assumes BT clocks per bit at the block
`timescale 1ns/1ns
module spcb_peer #(
    parameter int BT = 32
) (
    input  wire logic       clock,
    input  wire logic       go,
    input  wire logic [7:0] dat,
    input  wire logic       nine,
    input  wire logic       stop,
    output wire logic       line,
    output wire logic       busy
);
    logic [10:0] sh;
    int          nb = 0;
    int          cnt;
    // line rests at the idle mark between frames
    assign line = (nb != 0) ? sh[0] : 1'b1;
    assign busy = (nb != 0);
    // start bit, data lsb first, ninth bit, stop bit
    always @(posedge clock)
    begin
        if (go && nb == 0)
        begin
            sh <= {stop, nine, dat, 1'b0};
            nb <= 11;
            cnt <= BT - 1;
        end
        else if (nb != 0 && cnt == 0)
        begin
            sh <= sh >> 1;
            nb <= nb - 1;
            cnt <= BT - 1;
        end
        else if (nb != 0)
            cnt <= cnt - 1;
    end
endmodule

// ### dv/spcb_core_test.sv
// self-checking bench of the serial port block
// assumes peer and checker compiled first
`timescale 1ns/1ns
`include "spcb_map.vh"
module spcb_core_test;
    logic        clock;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        go;
    logic [7:0]  pdat;
    logic        pnine;
    logic        pstop;
    logic [31:0] rd;
    logic        err;
    wire  [31:0] prdata;
    wire         pready, pslverr, txd, rxd_in, rxd_out, rxd_oe, irq;
    wire         pline, pbusy;
    int          fail_count, compares, waits;
    // pin: block while it drives, else peer
    assign rxd_in = rxd_oe ? rxd_out : pline;
    spcb_core dut (.clock(clock), .rst_n(rst_n), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .txd(txd), .rxd_in(rxd_in), .rxd_out(rxd_out),
        .rxd_oe(rxd_oe), .irq(irq));
    spcb_peer #(.BT(32)) peer (.clock(clock), .go(go), .dat(pdat),
        .nine(pnine), .stop(pstop), .line(pline), .busy(pbusy));
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tmo(int n, int lim);
        if (n >= lim)
        begin
            check("wait bound", 32'h0, 32'h1);
            complete_run;
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        waits = 0;
        do begin @(posedge clock); waits++; end
        while (pready !== 1'b1 && waits < 2000);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        tmo(waits, 2000);
    endtask
    task automatic rdchk(logic [7:0] a, logic [31:0] exp, string nm);
        apb(1'b0, a, 32'h0);
        check(nm, exp, rd);
    endtask
    task automatic wait_txd(logic v, output int n);
        n = 0;
        while (txd !== v && n < 2000) begin @(posedge clock); n++; end
        tmo(n, 2000);
    endtask
    task automatic send(logic [7:0] d, logic n9, logic st);
        int n;
        pdat <= d; pnine <= n9; pstop <= st; go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        n = 0;
        do begin @(posedge clock); n++; end while (pbusy && n < 1000);
        tmo(n, 1000);
        repeat (40) @(posedge clock);
    endtask
    task automatic t_reset;
        rdchk(`SPCB_ADDR_CTRL, 32'h0, "ctrl");
        rdchk(`SPCB_ADDR_BUF, 32'h0, "buf");
        rdchk(8'h40, 32'h0, "unmapped data");
        check("unmapped err", 32'h1, err);
        $display("t_reset done");
    endtask
    task automatic t_tx;
        logic [10:0] fr;
        int n;
        fr = {2'b11, 8'hA5, 1'b0};
        apb(1'b1, `SPCB_ADDR_MODE, 32'h06);
        apb(1'b1, `SPCB_ADDR_CTRL, 32'h88);
        rdchk(`SPCB_ADDR_CTRL, 32'h88, "ctrl");
        apb(1'b1, `SPCB_ADDR_BUF, 32'hA5);
        wait_txd(1'b0, n);
        repeat (15) @(posedge clock);
        for (int k = 0; k < 11; k++)
        begin
            check("txd bit", fr[k], txd);
            repeat (32) @(posedge clock);
        end
        check("irq on", 32'h1, irq);
        rdchk(`SPCB_ADDR_CTRL, 32'h8A, "ctrl");
        apb(1'b1, `SPCB_ADDR_MODE, 32'h02);
        repeat (2) @(posedge clock);
        check("irq off", 32'h0, irq);
        apb(1'b1, `SPCB_ADDR_CTRL, 32'h88);
        rdchk(`SPCB_ADDR_CTRL, 32'h88, "ctrl");
        $display("t_tx done");
    endtask
    task automatic t_rx;
        apb(1'b1, `SPCB_ADDR_CTRL, 32'hB0);
        send(8'h3C, 1'b0, 1'b1);
        rdchk(`SPCB_ADDR_CTRL, 32'hB0, "ctrl");
        send(8'hC3, 1'b1, 1'b1);
        rdchk(`SPCB_ADDR_CTRL, 32'hB5, "ctrl");
        rdchk(`SPCB_ADDR_BUF, 32'hC3, "rx buf");
        apb(1'b1, `SPCB_ADDR_MODE, 32'h03);
        apb(1'b1, `SPCB_ADDR_CTRL, 32'h10);
        send(8'h5A, 1'b1, 1'b0);
        rdchk(`SPCB_ADDR_CTRL, 32'h95, "ctrl");
        rdchk(`SPCB_ADDR_BUF, 32'h5A, "rx buf");
        apb(1'b1, `SPCB_ADDR_MODE, 32'h02);
        apb(1'b1, `SPCB_ADDR_CTRL, 32'h80);
        send(8'h11, 1'b1, 1'b1);
        rdchk(`SPCB_ADDR_BUF, 32'h5A, "rx off buf");
        $display("t_rx done");
    endtask
    task automatic t_mode0;
        int a;
        int b;
        apb(1'b1, `SPCB_ADDR_MODE, 32'h00);
        for (int m = 0; m < 2; m++)
        begin
            apb(1'b1, `SPCB_ADDR_CTRL, m ? 32'h20 : 32'h00);
            apb(1'b1, `SPCB_ADDR_BUF, 32'h0F);
            wait_txd(1'b0, a);
            wait_txd(1'b1, a);
            wait_txd(1'b0, b);
            check("mode0 period", m ? 4 : 12, a + b);
            repeat (150) @(posedge clock);
        end
        $display("t_mode0 done");
    endtask
    // line slower than bus: queue fills, bus stalls
    task automatic t_fill;
        apb(1'b1, `SPCB_ADDR_MODE, 32'h02);
        apb(1'b1, `SPCB_ADDR_CTRL, 32'h80);
        for (int i = 0; i < 18; i++)
            apb(1'b1, `SPCB_ADDR_BUF, 32'(i));
        check("fifo stall", 32'h1, waits > 100);
        repeat (6600) @(posedge clock);
        check("txd idle", 32'h1, txd);
        $display("t_fill done");
    endtask
    initial
    begin
        fail_count = 0;
        compares = 0;
        rst_n = 1'b0;
        {psel, penable, pwrite, go, pnine, pstop} = 6'h00;
        {paddr, pdat, pwdata} = 48'h0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        t_reset;
        t_tx;
        t_rx;
        t_mode0;
        t_fill;
        complete_run;
    end
endmodule
bind spcb_core spcb_props u_props (.clock(clock), .rst_n(rst_n),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txd(txd), .rxd_in(rxd_in), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .irq(irq));
